// file: rtl/bcd_defines.vh
// Purpose: Constants for the byte core opcode decoder
// Assumes: Included by bare name from rtl files
// Notes:   Codes are 8-bit opcodes; operation and source codes are local
//
// Operation
// - Add without carry: 28-2F,25,26-27,24, one cycle
// - Add with carry: 38-3F,35,36-37,34, one cycle
// - Subtract with borrow: 98-9F,95,96-97,94
// - AND into accumulator: 58-5F,55,56-57,54
// - AND direct: 52 two bytes; 53 three/two
// - OR into accumulator: 48-4F,45,46-47,44
// - OR direct: 42 two bytes; 43 three/two
// - XOR into accumulator: 68-6F,65,66-67,64
// - XOR direct: 62 two bytes; 63 three/two
// - Rotates 23,33,03,13: one byte, one cycle
// - Accumulator loads E8-EF,E5,E6-E7,74 one cycle
// - Register loads F8-FF, A8-AF, 78-7F
// - Direct stores F5,88-8F,85,86-87,75
// - Indirect stores F6-F7, A6-A7, 76-77
// - 90 loads data pointer: three bytes, two cycles
// - 93 code table read: one byte, two cycles
// - External moves E2-E3,E0,F2-F3,F0: one/two
// - Push C0, pop D0: two bytes, two cycles
// - Exchange C8-CF, C5, C6-C7: one cycle
`ifndef BCD_DEFINES_VH
`define BCD_DEFINES_VH

// ==========================================================
// Operation codes
`define BCD_OP_ILLEGAL   5'h00
`define BCD_OP_ADD       5'h01
`define BCD_OP_ADD_WITH_CARRY      5'h02
`define BCD_OP_SUBTRACT_WITH_BORROW      5'h03
`define BCD_OP_AND       5'h04
`define BCD_OP_OR        5'h05
`define BCD_OP_XOR       5'h06
`define BCD_OP_INC       5'h07
`define BCD_OP_DEC       5'h08
`define BCD_OP_INC_DP    5'h09
`define BCD_OP_MUL       5'h0a
`define BCD_OP_DIV       5'h0b
`define BCD_OP_DADJ      5'h0c
`define BCD_OP_CLR       5'h0d
`define BCD_OP_CPL       5'h0e
`define BCD_OP_SWAP      5'h0f
`define BCD_OP_RL        5'h10
`define BCD_OP_RLC       5'h11
`define BCD_OP_RR        5'h12
`define BCD_OP_RRC       5'h13
`define BCD_OP_MOV       5'h14
`define BCD_OP_LD_DP     5'h15
`define BCD_OP_CODE_RD   5'h16
`define BCD_OP_EXT_RD    5'h17
`define BCD_OP_EXT_WR    5'h18
`define BCD_OP_PUSH      5'h19
`define BCD_OP_POP       5'h1a
`define BCD_OP_EXCH      5'h1b

// ==========================================================
// Operand source / destination codes
`define BCD_LOC_NONE     3'h0
`define BCD_LOC_ACC      3'h1
`define BCD_LOC_REG      3'h2
`define BCD_LOC_DIR      3'h3
`define BCD_LOC_IND      3'h4
`define BCD_LOC_IMM      3'h5
`define BCD_LOC_DATA_POINTER     3'h6
`define BCD_LOC_IMM16    3'h7

// ==========================================================
// Field positions within the opcode
`define BCD_REG_MSB      2
`define BCD_IND_BIT      0

`endif

// file: rtl/bcd_table.v
// Purpose: Combinational opcode table for the byte core decoder
// Assumes: Opcode is the first fetched byte of an instruction
// Notes:   Unknown or excluded opcodes report as illegal, length zero
`include "bcd_defines.vh"

module bcd_table (
	// Opcode in
	input  wire [7:0] i_opcode,   // First instruction byte
	// Decoded fields
	output reg  [4:0] o_op,       // Operation code
	output reg  [2:0] o_src,      // Operand source
	output reg  [2:0] o_dst,      // Destination
	output reg  [1:0] o_bytes,    // Instruction length
	output reg  [2:0] o_cycles,   // Machine cycles
	output reg        o_valid     // Opcode known
);

	// ==========================================================
	// Arithmetic/logic group helper: low nibble selects source
	function [2:0] alu_src;
		input [7:0] opc;
		begin
			if (opc[3]) begin
				alu_src = `BCD_LOC_REG;
			end else if (opc[3:1] == 3'h3) begin
				alu_src = `BCD_LOC_IND;
			end else if (opc[3:0] == 4'h5) begin
				alu_src = `BCD_LOC_DIR;
			end else begin
				alu_src = `BCD_LOC_IMM;
			end
		end
	endfunction

	// True when low nibble is one of the four accumulator-source forms
	function is_alu_form;
		input [7:0] opc;
		begin
			is_alu_form = opc[3] | (opc[3:2] == 2'h1);
		end
	endfunction

	// ==========================================================
	// Main decode; every path assigns all outputs
	always @* begin
		o_op     = `BCD_OP_ILLEGAL;
		o_src    = `BCD_LOC_NONE;
		o_dst    = `BCD_LOC_NONE;
		o_bytes  = 2'h0;
		o_cycles = 3'h0;
		o_valid  = 1'b0;
		// Accumulator-target ALU rows share one shape
		if (is_alu_form(i_opcode) && (i_opcode[7:4] == 4'h2 || i_opcode[7:4] == 4'h3 ||
			i_opcode[7:4] == 4'h9 || i_opcode[7:4] == 4'h5 || i_opcode[7:4] == 4'h4 ||
			i_opcode[7:4] == 4'h6 || i_opcode[7:4] == 4'he)) begin
			o_valid  = 1'b1;
			o_src    = alu_src(i_opcode);
			o_dst    = `BCD_LOC_ACC;
			o_cycles = 3'h1;
			// Immediate and direct forms carry one operand byte
			o_bytes  = (o_src == `BCD_LOC_DIR || o_src == `BCD_LOC_IMM) ? 2'h2 : 2'h1;
			case (i_opcode[7:4])
				4'h2: o_op = `BCD_OP_ADD;
				4'h3: o_op = `BCD_OP_ADD_WITH_CARRY;
				4'h9: o_op = `BCD_OP_SUBTRACT_WITH_BORROW;
				4'h5: o_op = `BCD_OP_AND;
				4'h4: o_op = `BCD_OP_OR;
				4'h6: o_op = `BCD_OP_XOR;
				default: begin
					// Row E: loads; immediate load lives at 74, E4 is clear
					o_op = `BCD_OP_MOV;
					if (i_opcode[3:0] == 4'h4) begin
						o_op    = `BCD_OP_CLR;
						o_src   = `BCD_LOC_NONE;
						o_bytes = 2'h1;
					end
				end
			endcase
		end else if (i_opcode == 8'h74) begin
			o_valid = 1'b1; o_op = `BCD_OP_MOV; o_src = `BCD_LOC_IMM;
			o_dst = `BCD_LOC_ACC; o_bytes = 2'h2; o_cycles = 3'h1;
		end else if (i_opcode[7:4] == 4'h0 || i_opcode[7:4] == 4'h1) begin
			// Increments and decrements, plus right rotates at x3
			o_valid = 1'b1; o_bytes = 2'h1; o_cycles = 3'h1;
			o_op = i_opcode[4] ? `BCD_OP_DEC : `BCD_OP_INC;
			if (i_opcode[3]) begin
				o_dst = `BCD_LOC_REG;
			end else if (i_opcode[3:1] == 3'h3) begin
				o_dst = `BCD_LOC_IND;
			end else if (i_opcode[3:0] == 4'h5) begin
				o_dst = `BCD_LOC_DIR; o_bytes = 2'h2;
			end else if (i_opcode[3:0] == 4'h4) begin
				o_dst = `BCD_LOC_ACC;
			end else if (i_opcode[3:0] == 4'h3) begin
				o_dst = `BCD_LOC_ACC;
				o_op  = i_opcode[4] ? `BCD_OP_RRC : `BCD_OP_RR;
			end else begin
				o_valid = 1'b0; o_op = `BCD_OP_ILLEGAL; o_bytes = 2'h0; o_cycles = 3'h0;
			end
		end else if (i_opcode[7:4] == 4'h7 && (i_opcode[3] || i_opcode[3:1] == 3'h3)) begin
			o_valid = 1'b1; o_op = `BCD_OP_MOV; o_src = `BCD_LOC_IMM;
			o_dst = i_opcode[3] ? `BCD_LOC_REG : `BCD_LOC_IND;
			o_bytes = 2'h2; o_cycles = 3'h1;
		end else if (i_opcode[7:4] == 4'hf && (i_opcode[3] || i_opcode[3:1] == 3'h3)) begin
			o_valid = 1'b1; o_op = `BCD_OP_MOV; o_src = `BCD_LOC_ACC;
			o_dst = i_opcode[3] ? `BCD_LOC_REG : `BCD_LOC_IND;
			o_bytes = 2'h1; o_cycles = 3'h1;
		end else if (i_opcode[7:4] == 4'ha && (i_opcode[3] || i_opcode[3:1] == 3'h3)) begin
			o_valid = 1'b1; o_op = `BCD_OP_MOV; o_src = `BCD_LOC_DIR;
			o_dst = i_opcode[3] ? `BCD_LOC_REG : `BCD_LOC_IND;
			o_bytes = 2'h2; o_cycles = 3'h2;
		end else if (i_opcode[7:4] == 4'h8 && (i_opcode[3] || i_opcode[3:0] >= 4'h5)) begin
			// Direct stores: register, direct, indirect
			o_valid = 1'b1; o_op = `BCD_OP_MOV; o_dst = `BCD_LOC_DIR;
			o_src = alu_src(i_opcode); o_cycles = 3'h2;
			o_bytes = (o_src == `BCD_LOC_DIR) ? 2'h3 : 2'h2;
		end else if (i_opcode[7:4] == 4'hc && (i_opcode[3] || i_opcode[3:1] == 3'h3 ||
			i_opcode[3:0] == 4'h5)) begin
			o_valid = 1'b1; o_op = `BCD_OP_EXCH; o_dst = `BCD_LOC_ACC;
			o_src = alu_src(i_opcode); o_cycles = 3'h1;
			o_bytes = (o_src == `BCD_LOC_DIR) ? 2'h2 : 2'h1;
		end else begin
			o_valid = 1'b1; o_bytes = 2'h1; o_cycles = 3'h1;
			case (i_opcode)
				8'h52, 8'h42, 8'h62: begin
					o_op = (i_opcode[6:4] == 3'h5) ? `BCD_OP_AND :
						(i_opcode[6:4] == 3'h4) ? `BCD_OP_OR : `BCD_OP_XOR;
					o_src = `BCD_LOC_ACC; o_dst = `BCD_LOC_DIR; o_bytes = 2'h2;
				end
				8'h53, 8'h43, 8'h63: begin
					o_op = (i_opcode[6:4] == 3'h5) ? `BCD_OP_AND :
						(i_opcode[6:4] == 3'h4) ? `BCD_OP_OR : `BCD_OP_XOR;
					o_src = `BCD_LOC_IMM; o_dst = `BCD_LOC_DIR;
					o_bytes = 2'h3; o_cycles = 3'h2;
				end
				8'h23: begin o_op = `BCD_OP_RL;  o_dst = `BCD_LOC_ACC; end
				8'h33: begin o_op = `BCD_OP_RLC; o_dst = `BCD_LOC_ACC; end
				8'hf5: begin
					o_op = `BCD_OP_MOV; o_src = `BCD_LOC_ACC; o_dst = `BCD_LOC_DIR;
					o_bytes = 2'h2;
				end
				8'h75: begin
					o_op = `BCD_OP_MOV; o_src = `BCD_LOC_IMM; o_dst = `BCD_LOC_DIR;
					o_bytes = 2'h3; o_cycles = 3'h2;
				end
				8'h90: begin
					o_op = `BCD_OP_LD_DP; o_src = `BCD_LOC_IMM16; o_dst = `BCD_LOC_DATA_POINTER;
					o_bytes = 2'h3; o_cycles = 3'h2;
				end
				// Only the data-pointer form of the code read is decoded here
				8'h93: begin
					o_op = `BCD_OP_CODE_RD; o_src = `BCD_LOC_DATA_POINTER; o_dst = `BCD_LOC_ACC;
					o_cycles = 3'h2;
				end
				8'he0, 8'he2, 8'he3: begin
					o_op = `BCD_OP_EXT_RD; o_dst = `BCD_LOC_ACC; o_cycles = 3'h2;
					o_src = i_opcode[1] ? `BCD_LOC_IND : `BCD_LOC_DATA_POINTER;
				end
				8'hf0, 8'hf2, 8'hf3: begin
					o_op = `BCD_OP_EXT_WR; o_src = `BCD_LOC_ACC; o_cycles = 3'h2;
					o_dst = i_opcode[1] ? `BCD_LOC_IND : `BCD_LOC_DATA_POINTER;
				end
				8'hc0: begin
					o_op = `BCD_OP_PUSH; o_src = `BCD_LOC_DIR; o_bytes = 2'h2; o_cycles = 3'h2;
				end
				8'hd0: begin
					o_op = `BCD_OP_POP; o_dst = `BCD_LOC_DIR; o_bytes = 2'h2; o_cycles = 3'h2;
				end
				8'ha3: begin
					o_op = `BCD_OP_INC_DP; o_dst = `BCD_LOC_DATA_POINTER; o_cycles = 3'h2;
				end
				8'ha4: begin o_op = `BCD_OP_MUL; o_dst = `BCD_LOC_ACC; o_cycles = 3'h4; end
				8'h84: begin o_op = `BCD_OP_DIV; o_dst = `BCD_LOC_ACC; o_cycles = 3'h4; end
				8'hd4: begin o_op = `BCD_OP_DADJ; o_dst = `BCD_LOC_ACC; end
				8'hf4: begin o_op = `BCD_OP_CPL;  o_dst = `BCD_LOC_ACC; end
				8'hc4: begin o_op = `BCD_OP_SWAP; o_dst = `BCD_LOC_ACC; end
				default: begin
					// Excluded groups report illegal
					o_valid = 1'b0; o_bytes = 2'h0; o_cycles = 3'h0;
				end
			endcase
		end
	end

endmodule // bcd_table

// file: rtl/bcd_decode.v
// Purpose: Registered opcode decoder for an 8-bit accumulator core
// Assumes: Opcode strobe is synchronous to I_SYS_CLK
// Notes:   Result appears one clock after the strobe and holds
`include "bcd_defines.vh"

module bcd_decode (
	// Clock and reset
	input  wire       I_SYS_CLK,      // Core clock
	input  wire       I_RESET,        // Synchronous, active high
	// Opcode from program memory
	input  wire [7:0] I_OPCODE,       // First instruction byte
	input  wire       I_OPCODE_VALID, // Strobe: decode this byte
	// Decoded controls
	output reg  [4:0] O_OP,           // Operation code
	output reg  [2:0] O_SRC,          // Operand source
	output reg  [2:0] O_DST,          // Destination
	output reg  [1:0] O_BYTES,        // Length in bytes
	output reg  [2:0] O_CYCLES,       // Machine cycles
	output reg  [2:0] O_REG_SEL,      // Working register index
	output reg        O_IND_SEL,      // Indirect pointer register
	output reg        O_ILLEGAL,      // Opcode not decoded here
	output reg        O_DONE          // One-cycle result pulse
);

	// ==========================================================
	// Table outputs
	wire [4:0] t_op;     // Operation
	wire [2:0] t_src;    // Source
	wire [2:0] t_dst;    // Destination
	wire [1:0] t_bytes;  // Length
	wire [2:0] t_cycles; // Cycles
	wire       t_valid;  // Known opcode

	bcd_table u_table (
		.i_opcode (I_OPCODE),
		.o_op     (t_op),
		.o_src    (t_src),
		.o_dst    (t_dst),
		.o_bytes  (t_bytes),
		.o_cycles (t_cycles),
		.o_valid  (t_valid)
	);

	// ==========================================================
	// Output registers; held between strobes so the datapath can sample late
	always @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			O_OP      <= `BCD_OP_ILLEGAL;
			O_SRC     <= `BCD_LOC_NONE;
			O_DST     <= `BCD_LOC_NONE;
			O_BYTES   <= 2'h0;
			O_CYCLES  <= 3'h0;
			O_REG_SEL <= 3'h0;
			O_IND_SEL <= 1'b0;
			O_ILLEGAL <= 1'b0;
			O_DONE    <= 1'b0;
		end else begin
			O_DONE <= I_OPCODE_VALID;
			if (I_OPCODE_VALID) begin
				O_OP      <= t_op;
				O_SRC     <= t_src;
				O_DST     <= t_dst;
				O_BYTES   <= t_bytes;
				O_CYCLES  <= t_cycles;
				// Low opcode bits pick the register or pointer
				O_REG_SEL <= I_OPCODE[`BCD_REG_MSB:0];
				O_IND_SEL <= I_OPCODE[`BCD_IND_BIT];
				O_ILLEGAL <= ~t_valid;
			end
		end
	end

endmodule // bcd_decode

// file: tb/bcd_props.sv
// Purpose: Port-level checker for the opcode decoder
// Assumes: Sees only the ports of bcd_decode
// Notes:   Bound to every bcd_decode instance below
`include "bcd_defines.vh"
module bcd_props (
	// Clock and reset
	input wire       I_SYS_CLK,
	input wire       I_RESET,
	// Strobe side
	input wire [7:0] I_OPCODE,
	input wire       I_OPCODE_VALID,
	// Decoded side
	input wire [4:0] O_OP,
	input wire [2:0] O_SRC,
	input wire [2:0] O_DST,
	input wire [1:0] O_BYTES,
	input wire [2:0] O_CYCLES,
	input wire [2:0] O_REG_SEL,
	input wire       O_IND_SEL,
	input wire       O_ILLEGAL,
	input wire       O_DONE
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge I_SYS_CLK); endclocking
	default disable iff (I_RESET);
	// ==========================================================
	// Strobe and its answer one edge later
	sequence s_take;
		I_OPCODE_VALID;
	endsequence
	sequence s_answer;
		O_DONE;
	endsequence
	a_done_pulse: assert property (s_take |=> s_answer)
		else $error("no result pulse after strobe");
	a_no_spurious: assert property (!I_OPCODE_VALID |=> !O_DONE)
		else $error("result pulse without strobe");
	// Reset must clear, so this one is never disabled
	a_reset_clear: assert property (disable iff (1'b0)
		I_RESET |=> !O_DONE && O_OP == 5'h00 && !O_ILLEGAL && O_BYTES == 2'h0
		&& O_SRC == 3'h0 && O_DST == 3'h0 && O_CYCLES == 3'h0
		&& O_REG_SEL == 3'h0 && !O_IND_SEL)
		else $error("outputs not cleared by reset");
	a_fields_hold: assert property (!I_OPCODE_VALID |=> $stable(O_OP) && $stable(O_BYTES)
		&& $stable(O_SRC) && $stable(O_DST) && $stable(O_CYCLES) && $stable(O_ILLEGAL)
		&& $stable(O_REG_SEL) && $stable(O_IND_SEL))
		else $error("fields moved without strobe");
	a_illegal_len: assert property (O_DONE && O_ILLEGAL |-> O_BYTES == 2'h0 && O_CYCLES == 3'h0)
		else $error("illegal opcode with nonzero length");
	a_legal_len: assert property (O_DONE && !O_ILLEGAL |-> O_BYTES != 2'h0
		&& O_CYCLES inside {3'h1, 3'h2, 3'h4}) else $error("bad length for legal opcode");
	a_reg_copy: assert property (s_take |=> O_REG_SEL == $past(I_OPCODE[2:0])
		&& O_IND_SEL == $past(I_OPCODE[0])) else $error("register select wrong");
	a_add_direct: assert property (s_take and I_OPCODE == 8'h25 |=> O_OP == `BCD_OP_ADD
		&& O_BYTES == 2'h2 && O_CYCLES == 3'h1) else $error("direct add decoded wrong");
	a_mul_div: assert property (s_take and I_OPCODE inside {8'ha4, 8'h84} |=>
		O_CYCLES == 3'h4) else $error("multiply or divide not four cycles");
	a_code_read: assert property (s_take and I_OPCODE == 8'h93 |=>
		O_OP == `BCD_OP_CODE_RD && O_BYTES == 2'h1 && O_CYCLES == 3'h2)
		else $error("code read decoded wrong");
endmodule // bcd_props

bind bcd_decode bcd_props u_props (.I_SYS_CLK(I_SYS_CLK), .I_RESET(I_RESET),
	.I_OPCODE(I_OPCODE), .I_OPCODE_VALID(I_OPCODE_VALID), .O_OP(O_OP), .O_SRC(O_SRC),
	.O_DST(O_DST), .O_BYTES(O_BYTES), .O_CYCLES(O_CYCLES), .O_REG_SEL(O_REG_SEL),
	.O_IND_SEL(O_IND_SEL), .O_ILLEGAL(O_ILLEGAL), .O_DONE(O_DONE));

// file: tb/bcd_progmem.sv
// Purpose: Program memory model feeding opcode bytes
// Assumes: Contents loaded by the bench at time zero
// Notes:   Presents bytes on the falling edge
module bcd_progmem (
	input  wire       i_clk,    // Core clock
	input  wire       i_fetch,  // Present a byte this cycle
	input  wire [6:0] i_addr,   // Fetch address
	output logic [7:0] o_byte,  // Opcode byte
	output logic       o_valid  // Byte strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:127];    // Code store
	initial begin
		o_byte = 8'h00;
		o_valid = 1'b0;
	end
	// ==========================================================
	// Idle bus shows the inverse of the last byte, so a decoder
	// that ignores the strobe cannot pass by luck
	always @(negedge i_clk) begin
		o_valid <= i_fetch;
		o_byte <= i_fetch ? mem[i_addr] : ~o_byte;
	end
endmodule // bcd_progmem

// file: tb/bcd_decode_tb.sv
// Purpose: Self-checking bench for the opcode decoder
// Assumes: Rows hold opcode, operation, source, destination, bytes, cycles
// Notes:   Rows run back to back with the strobe held high
`include "bcd_defines.vh"
module bcd_decode_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk, rst, fetch, vld, done, ill, ind;
	logic [6:0] addr;
	logic [7:0] opc;
	logic [4:0] op;
	logic [2:0] src, dst, cyc, rsel;
	logic [1:0] nb;
	int         err_count, comparisons, ticks;
	// Row: opcode, operation, source, destination, bytes, cycles
	// Source and destination are checked per row so every operand class is seen
	logic [31:0] rows [$] = {
		32'h28012111, 32'h2f012111, 32'h25013121, 32'h26014111, 32'h27014111,
		32'h24015121, 32'h38022111, 32'h3f022111, 32'h35023121, 32'h36024111,
		32'h34025121, 32'h98032111, 32'h9f032111, 32'h95033121, 32'h97034111,
		32'h94035121, 32'h58042111, 32'h55043121, 32'h56044111, 32'h54045121,
		32'h52041321, 32'h53045332, 32'h48052111, 32'h4f052111, 32'h45053121,
		32'h46054111, 32'h44055121, 32'h42051321, 32'h43055332,
		32'h68062111, 32'h65063121, 32'h67064111, 32'h64065121, 32'h62061321,
		32'h63065332, 32'h23100111, 32'h33110111, 32'h03120111, 32'h13130111,
		32'he8142111, 32'he5143121, 32'he6144111, 32'h74145121,
		32'hf8141211, 32'hff141211, 32'ha8143222, 32'h78145221,
		32'hf5141321, 32'h88142322, 32'h85143332, 32'h86144322, 32'h75145332,
		32'hf6141411, 32'ha7143422, 32'h76145421,
		32'h90157632, 32'h93166112,
		32'he2174112, 32'he3174112, 32'he0176112, 32'hf2181412, 32'hf0181612,
		32'hc0193022, 32'hd01a0322, 32'hc81b2111, 32'hc51b3121, 32'hc61b4111,
		32'h04070111, 32'h08070211, 32'h05070321, 32'h06070411, 32'h14080111,
		32'h1f080211, 32'h15080321, 32'h16080411, 32'ha3090612,
		32'ha40a0114, 32'h840b0114, 32'hd40c0111,
		32'h00000000, 32'h02000000, 32'hd6000000, 32'hc2000000, 32'h80000000, // Not decoded here
		32'he40d0111, 32'hf40e0111, 32'hc40f0111};

	bcd_progmem pm (.i_clk(clk), .i_fetch(fetch), .i_addr(addr), .o_byte(opc), .o_valid(vld));
	bcd_decode dut (.I_SYS_CLK(clk), .I_RESET(rst), .I_OPCODE(opc), .I_OPCODE_VALID(vld),
		.O_OP(op), .O_SRC(src), .O_DST(dst), .O_BYTES(nb), .O_CYCLES(cyc),
		.O_REG_SEL(rsel), .O_IND_SEL(ind), .O_ILLEGAL(ill), .O_DONE(done));

	// ==========================================================
	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		ticks++;
		if (ticks == 1000) begin
			err_count++;
			close_out();
		end
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic check_row(input logic [31:0] r);
		check({7'h0, done}, 8'h01);
		check({3'h0, op}, r[23:16]);
		check({5'h0, src}, {4'h0, r[15:12]});
		check({5'h0, dst}, {4'h0, r[11:8]});
		check({6'h0, nb}, {4'h0, r[7:4]});
		check({5'h0, cyc}, {4'h0, r[3:0]});
		check({7'h0, ill}, {7'h0, r[23:16] == 8'h00});
		check({5'h0, rsel}, {5'h0, r[26:24]});
		check({7'h0, ind}, {7'h0, r[24]});
	endtask

	task automatic close_out;
		$display("Counts: comparisons=%0d mismatches=%0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		rst = 1'b1;
		fetch = 1'b0;
		addr = 7'h00;
		foreach (rows[i]) pm.mem[i] = rows[i][31:24];
		pm.mem[126] = 8'h25;
		pm.mem[127] = 8'ha4;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		// Table, one opcode per cycle
		for (int i = 0; i <= rows.size(); i++) begin
			@(posedge clk);
			#1;
			if (i > 0) check_row(rows[i-1]);
			fetch = (i < rows.size());
			addr = i[6:0];
		end
		$display("test table done");
		// Idle: no pulse, last fields kept
		repeat (3) @(posedge clk);
		#1;
		check({7'h0, done}, 8'h00);
		check({3'h0, op}, {3'h0, `BCD_OP_SWAP});
		check({5'h0, dst}, {5'h0, `BCD_LOC_ACC});
		check({6'h0, nb}, 8'h01);
		$display("test hold done");
		// Reset in mid-stream, then decode straight after it
		fetch = 1'b1;
		addr = 7'h7f;
		@(negedge clk);
		rst = 1'b1;
		@(posedge clk);
		#1;
		check({7'h0, done}, 8'h00);
		check({3'h0, op}, 8'h00);
		check({7'h0, ill}, 8'h00);
		check({5'h0, dst}, 8'h00);
		check({6'h0, nb}, 8'h00);
		check({5'h0, cyc}, 8'h00);
		@(negedge clk);
		rst = 1'b0;
		@(posedge clk);
		#1;
		check({5'h0, cyc}, 8'h04);
		check({3'h0, op}, {3'h0, `BCD_OP_MUL});
		check({7'h0, done}, 8'h01);
		addr = 7'h7e;
		@(posedge clk);
		#1;
		check({5'h0, src}, {5'h0, `BCD_LOC_DIR});
		check({5'h0, dst}, {5'h0, `BCD_LOC_ACC});
		$display("test reset done");
		close_out();
	end
endmodule // bcd_decode_tb
